// ---- adoc_pkg.sv ----
package adoc_pkg;
    localparam int          DATA_W          = 10;
    localparam int          NUM_STAGES      = 8;
    localparam int          STAGE_W         = 2;
    localparam int          LATENCY         = 7;
    localparam int          LOCK_CYCLES     = 8;
    localparam int          LINK_PERIOD_NS  = 12;
    localparam int          MIN_RATE_MHZ    = 20;
    localparam int          LINK_RATE_MHZ   = 1000 / LINK_PERIOD_NS;
    // Link clocks per sampling edge above which the sample clock counts as stopped
    localparam int          STALL_TICKS     = (LINK_RATE_MHZ + MIN_RATE_MHZ - 1) / MIN_RATE_MHZ;
    localparam logic [7:0]  REG_PWR_MODE    = 8'h08;
    localparam logic [7:0]  REG_OUT_MODE    = 8'h14;
    localparam logic [7:0]  REG_FORMAT      = 8'h15;
    localparam logic [7:0]  REG_STATUS      = 8'h16;
    localparam logic [7:0]  PWR_MODE_RST    = 8'h00;
    localparam logic [7:0]  OUT_MODE_RST    = 8'h00;
    localparam logic [7:0]  FORMAT_RST      = 8'h01;
    localparam int          PWR_FULL_BIT    = 0;
    localparam int          DDR_BIT         = 3;
    localparam int          TWOS_BIT        = 0;
    localparam int          LOWSWING_BIT    = 1;
    localparam int          DCS_EN_BIT      = 0;

    typedef enum logic [3:0] {
        ADOC_RUN     = 4'b0001,
        ADOC_STANDBY = 4'b0010,
        ADOC_OFF     = 4'b0100,
        ADOC_WAKE    = 4'b1000
    } adoc_state_e;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              out_of_range;
    } adoc_word_s;

    typedef struct packed {
        logic [NUM_STAGES-2:0][STAGE_W-1:0] stage_code;
        logic                               last_bit;
        logic                               over;
        logic                               under;
    } adoc_raw_s;
endpackage : adoc_pkg

// ---- adoc_top.sv ----
`timescale 1ns/1ps
module adoc_top (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               link_clk,
    input  wire adoc_pkg::adoc_raw_s raw_in,
    input  wire logic               power_down_pin,
    input  wire logic               cfg_we,
    input  wire logic [7:0]         cfg_addr,
    input  wire logic [7:0]         cfg_wdata,
    output logic [7:0]              cfg_rdata,
    output logic [9:0]              dout,
    output logic                    dout_oe_n,
    output logic                    or_out,
    output logic                    data_output_clock,
    output logic                    duty_cycle_stabilizer_locked,
    output logic                    low_swing,
    output logic                    ddr_mode
);
    localparam int LW = adoc_pkg::DATA_W;
    localparam int NS = adoc_pkg::NUM_STAGES;

    logic       rst_s1_q, rst_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_q    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q    <= rst_s1_q;
        end
    end

    // Configuration registers
    logic [7:0] pwr_mode_q, out_mode_q, format_q;
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            pwr_mode_q <= adoc_pkg::PWR_MODE_RST;
            out_mode_q <= adoc_pkg::OUT_MODE_RST;
            format_q   <= adoc_pkg::FORMAT_RST;
        end else if (cfg_we) begin
            case (cfg_addr)
                adoc_pkg::REG_PWR_MODE: pwr_mode_q <= cfg_wdata;
                adoc_pkg::REG_OUT_MODE: out_mode_q <= cfg_wdata;
                adoc_pkg::REG_FORMAT:   format_q   <= cfg_wdata;
                default: ;
            endcase
        end
    end

    logic       pd_s1_q, pd_q;
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            pd_s1_q <= 1'b0;
            pd_q    <= 1'b0;
        end else begin
            pd_s1_q <= power_down_pin;
            pd_q    <= pd_s1_q;
        end
    end

    // Clock-rate watchdog on the link clock: toggle from clk crosses over
    logic       tog_q;
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) tog_q <= 1'b0;
        else        tog_q <= ~tog_q;
    end

    logic       lrst_s1_q, lrst_q;
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst_s1_q <= 1'b0;
            lrst_q    <= 1'b0;
        end else begin
            lrst_s1_q <= 1'b1;
            lrst_q    <= lrst_s1_q;
        end
    end

    logic       ltog_s1_q, ltog_s2_q, ltog_s3_q, slow_q;
    logic [7:0] idle_cnt_q;
    always_ff @(posedge link_clk or negedge lrst_q) begin
        if (!lrst_q) begin
            ltog_s1_q  <= 1'b0;
            ltog_s2_q  <= 1'b0;
            ltog_s3_q  <= 1'b0;
            idle_cnt_q <= 8'h00;
            slow_q     <= 1'b0;
        end else begin
            ltog_s1_q <= tog_q;
            ltog_s2_q <= ltog_s1_q;
            ltog_s3_q <= ltog_s2_q;
            if (ltog_s2_q != ltog_s3_q) begin
                idle_cnt_q <= 8'h00;
                slow_q     <= 1'b0;
            end else if (idle_cnt_q >= 8'(adoc_pkg::STALL_TICKS)) begin
                slow_q     <= 1'b1;
            end else begin
                idle_cnt_q <= idle_cnt_q + 8'h01;
            end
        end
    end

    logic       slow_s1_q, slow_s2_q;
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            slow_s1_q <= 1'b0;
            slow_s2_q <= 1'b0;
        end else begin
            slow_s1_q <= slow_q;
            slow_s2_q <= slow_s1_q;
        end
    end

    // Power state
    adoc_pkg::adoc_state_e state_q;
    logic [3:0]            wake_cnt_q;
    logic                  conv_en;
    assign conv_en = (state_q == adoc_pkg::ADOC_RUN) || (state_q == adoc_pkg::ADOC_WAKE);
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            state_q    <= adoc_pkg::ADOC_RUN;
            wake_cnt_q <= 4'h0;
        end else begin
            case (state_q)
                adoc_pkg::ADOC_RUN: begin
                    if (pd_q)
                        state_q <= pwr_mode_q[adoc_pkg::PWR_FULL_BIT] ? adoc_pkg::ADOC_OFF
                                                                       : adoc_pkg::ADOC_STANDBY;
                    else if (slow_s2_q)
                        state_q <= adoc_pkg::ADOC_STANDBY;
                end
                adoc_pkg::ADOC_STANDBY, adoc_pkg::ADOC_OFF: begin
                    if (!pd_q && !slow_s2_q) begin
                        state_q    <= adoc_pkg::ADOC_WAKE;
                        wake_cnt_q <= 4'h0;
                    end
                end
                adoc_pkg::ADOC_WAKE: begin
                    if (pd_q || slow_s2_q)
                        state_q <= adoc_pkg::ADOC_STANDBY;
                    else if (wake_cnt_q == 4'(adoc_pkg::LATENCY - 1))
                        state_q <= adoc_pkg::ADOC_RUN;
                    else
                        wake_cnt_q <= wake_cnt_q + 4'h1;
                end
                default: state_q <= adoc_pkg::ADOC_RUN;
            endcase
        end
    end

    // Stabilizer lock model: relock after enable or wake
    logic [3:0] lock_cnt_q;
    logic       dcs_en;
    assign dcs_en = format_q[adoc_pkg::DCS_EN_BIT];
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) lock_cnt_q <= 4'h0;
        else if (!dcs_en || !conv_en) lock_cnt_q <= 4'h0;
        else if (lock_cnt_q != 4'(adoc_pkg::LOCK_CYCLES)) lock_cnt_q <= lock_cnt_q + 4'h1;
    end
    assign duty_cycle_stabilizer_locked = dcs_en && (lock_cnt_q == 4'(adoc_pkg::LOCK_CYCLES));

    // Correction: overlap-add of stage codes, one redundant bit per stage
    function automatic logic [LW:0] correct(input adoc_pkg::adoc_raw_s r);
        logic [LW+1:0] acc;
        acc = '0;
        for (int i = 0; i < NS - 1; i++)
            acc = acc + ({10'h000, r.stage_code[i]} << (NS - 1 - i));
        acc = acc + {11'h000, r.last_bit};
        if (r.over)       correct = {1'b1, 10'h3ff};
        else if (r.under) correct = {1'b1, 10'h000};
        else if (acc > 12'h3ff) correct = {1'b1, 10'h3ff};
        else              correct = {1'b0, acc[LW-1:0]};
    endfunction : correct

    // Corrected word for the sample at the pins this edge
    logic [LW:0] corr;
    assign corr = correct(raw_in);

    // Pipeline: new sample each edge, older ones shift on
    adoc_pkg::adoc_word_s pipe_q [adoc_pkg::LATENCY];
    logic [adoc_pkg::LATENCY-1:0] vld_q;
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            for (int i = 0; i < adoc_pkg::LATENCY; i++) pipe_q[i] <= '0;
            vld_q <= '0;
        end else begin
            pipe_q[0] <= {corr[LW-1:0], corr[LW]};
            vld_q[0]  <= conv_en;
            for (int i = 1; i < adoc_pkg::LATENCY; i++) begin
                pipe_q[i] <= pipe_q[i-1];
                vld_q[i]  <= vld_q[i-1] && conv_en;
            end
        end
    end

    logic out_twos;
    assign out_twos = out_mode_q[adoc_pkg::TWOS_BIT];

    function automatic logic [9:0] pwr_fmt(input logic [9:0] d);
        pwr_fmt = out_twos ? {~d[9], d[8:0]} : d;
    endfunction : pwr_fmt

    logic [9:0] dout_q;
    logic       or_q, oe_n_q;
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            dout_q <= 10'h000;
            or_q   <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= (state_q == adoc_pkg::ADOC_OFF);
            if (state_q == adoc_pkg::ADOC_RUN && vld_q[adoc_pkg::LATENCY-1]) begin
                // Last stage registered here lands LATENCY edges after sampling
                dout_q <= pwr_fmt(pipe_q[adoc_pkg::LATENCY-1].data);
                or_q   <= pipe_q[adoc_pkg::LATENCY-1].out_of_range;
            end
        end
    end

    assign dout              = dout_q;
    assign or_out            = or_q;
    assign dout_oe_n         = oe_n_q;
    assign data_output_clock = clk & ~oe_n_q;
    assign low_swing         = format_q[adoc_pkg::LOWSWING_BIT];
    assign ddr_mode          = out_mode_q[adoc_pkg::DDR_BIT];

    always_comb begin
        case (cfg_addr)
            adoc_pkg::REG_PWR_MODE: cfg_rdata = pwr_mode_q;
            adoc_pkg::REG_OUT_MODE: cfg_rdata = out_mode_q;
            adoc_pkg::REG_FORMAT:   cfg_rdata = format_q;
            adoc_pkg::REG_STATUS:   cfg_rdata = {3'h0, duty_cycle_stabilizer_locked, state_q};
            default:                cfg_rdata = 8'h00;
        endcase
    end

    property p_latency;
        @(posedge clk) disable iff (!rst_q)
        $past(state_q == adoc_pkg::ADOC_RUN && vld_q[adoc_pkg::LATENCY-1])
        |-> {or_out, dout} == {$past(corr[LW], 8), $past(corr[LW-1:0], 8) ^ {$past(out_twos), 9'h000}};
    endproperty
    a_latency: assert property (p_latency) else $error("Output word latency wrong");

    property p_hiz;
        @(posedge clk) disable iff (!rst_q)
        (state_q == adoc_pkg::ADOC_OFF) |=> dout_oe_n;
    endproperty
    a_hiz: assert property (p_hiz) else $error("Drivers not off in power-down");

    property p_pd_enter;
        @(posedge clk) disable iff (!rst_q)
        (state_q == adoc_pkg::ADOC_RUN && pd_q) |=> state_q != adoc_pkg::ADOC_RUN;
    endproperty
    a_pd_enter: assert property (p_pd_enter) else $error("Power-down not entered");

    property p_wake;
        @(posedge clk) disable iff (!rst_q)
        ($rose(state_q == adoc_pkg::ADOC_WAKE)) |-> (state_q == adoc_pkg::ADOC_WAKE)[*7];
    endproperty
    a_wake: assert property (p_wake) else $error("Resumed before latency elapsed");

    property p_lock;
        @(posedge clk) disable iff (!rst_q)
        $rose(duty_cycle_stabilizer_locked) |-> $past(dcs_en && conv_en, 8);
    endproperty
    a_lock: assert property (p_lock) else $error("Stabilizer locked too early");

    property p_dcs_off;
        @(posedge clk) disable iff (!rst_q)
        !dcs_en |-> !duty_cycle_stabilizer_locked;
    endproperty
    a_dcs_off: assert property (p_dcs_off) else $error("Locked while stabilizer off");

    property p_slow;
        @(posedge clk) disable iff (!rst_q)
        (slow_s2_q && state_q == adoc_pkg::ADOC_RUN) |=> state_q == adoc_pkg::ADOC_STANDBY;
    endproperty
    a_slow: assert property (p_slow) else $error("Clock-rate standby missed");

    property p_resume;
        @(posedge clk) disable iff (!rst_q)
        (state_q == adoc_pkg::ADOC_STANDBY && !pd_q && !slow_s2_q) |=> state_q == adoc_pkg::ADOC_WAKE;
    endproperty
    a_resume: assert property (p_resume) else $error("No return from power-down");

    c_pd:   cover property (@(posedge clk) disable iff (!rst_q) state_q == adoc_pkg::ADOC_OFF);
    c_wake: cover property (@(posedge clk) disable iff (!rst_q) $fell(state_q == adoc_pkg::ADOC_WAKE));
    c_lock: cover property (@(posedge clk) disable iff (!rst_q) $rose(duty_cycle_stabilizer_locked));
endmodule : adoc_top

// ---- adoc_rx_model.sv ----
`timescale 1ns/1ps
module adoc_rx_model (
    input  wire logic        data_output_clock,
    input  wire logic        ddr_mode,
    input  wire logic [9:0]  dout,
    input  wire logic        or_out,
    output logic      [10:0] rx_q,
    output int               rise_cnt,
    output int               fall_cnt
);
    initial begin
        rx_q     = '0;
        rise_cnt = 0;
        fall_cnt = 0;
    end

    always @(posedge data_output_clock) begin
        rx_q     <= {or_out, dout};
        rise_cnt <= rise_cnt + 1;
    end

    // Falling edges only counted in double rate; no data captured on them
    always @(negedge data_output_clock) begin
        if (ddr_mode) begin
            fall_cnt <= fall_cnt + 1;
        end
    end
endmodule : adoc_rx_model

// ---- testbench.sv ----
`timescale 1ns/1ps
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin miscompares++; $display("ERROR %0t %s", $time, m); end end
module testbench;
    logic                clk, link_clk, clk_stop, rst_n, power_down_pin, cfg_we;
    adoc_pkg::adoc_raw_s raw_in;
    logic [7:0]          cfg_addr, cfg_wdata, cfg_rdata, v;
    logic [9:0]          dout;
    logic                dout_oe_n, or_out, data_output_clock, locked, low_swing, ddr_mode;
    logic [10:0]         rx_q;
    logic [10:0]         hist [0:15];
    logic [15:0]         lfsr;
    logic                twos, chk_en;
    int                  rise_cnt, fall_cnt, miscompares, comparisons, cyc, run_len, r0;

    adoc_top i_dut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .raw_in(raw_in),
        .power_down_pin(power_down_pin), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .dout(dout), .dout_oe_n(dout_oe_n), .or_out(or_out),
        .data_output_clock(data_output_clock), .duty_cycle_stabilizer_locked(locked),
        .low_swing(low_swing), .ddr_mode(ddr_mode));
    adoc_rx_model i_rx (.data_output_clock(data_output_clock), .ddr_mode(ddr_mode), .dout(dout),
        .or_out(or_out), .rx_q(rx_q), .rise_cnt(rise_cnt), .fall_cnt(fall_cnt));

    initial begin
        clk = 1'b0;
        forever begin
            #20;
            if (!clk_stop) clk = ~clk;
        end
    end
    initial begin
        link_clk = 1'b0;
        #3.3;
        forever #6 link_clk = ~link_clk;
    end

    function automatic logic [15:0] lfsr_next(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // Zero codes give zero; over forces full scale and under forces zero, whatever the codes
    function automatic logic [10:0] expect_word(adoc_pkg::adoc_raw_s r, logic tw);
        logic [9:0] d;
        d = r.over ? 10'h3ff : 10'h000;
        if (tw) d[9] = ~d[9];
        return {r.over | r.under, d};
    endfunction : expect_word

    task automatic next_raw();
        adoc_pkg::adoc_raw_s r;
        lfsr = lfsr_next(lfsr);
        r = {lfsr, lfsr[3]};
        r.over = (lfsr[1:0] == 2'h0);
        r.under = (lfsr[1:0] == 2'h1);
        if (lfsr[1] == 1'b1) r = '0;
        raw_in <= r;
    endtask : next_raw

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_we <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_we <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        cfg_addr <= a;
        #1;
        v = cfg_rdata;
    endtask : rd

    task automatic summarize();
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    always @(posedge clk) begin
        hist[cyc[3:0]] <= expect_word(raw_in, twos);
        cyc <= cyc + 1;
        run_len = chk_en ? run_len + 1 : 0;
        #1;
        if (run_len >= 9) `CHK({or_out, dout}, hist[(cyc - 8) & 15], "word")
        if (run_len >= 10) `CHK(rx_q, hist[(cyc - 9) & 15], "capture")
    end

    initial begin
        #100000;
        miscompares++;
        summarize();
    end

    initial begin
        clk_stop = 0; rst_n = 0; raw_in = '0; power_down_pin = 0; cfg_we = 0; cfg_addr = 0; cfg_wdata = 0;
        twos = 0; chk_en = 0; lfsr = 16'he129; miscompares = 0; comparisons = 0; cyc = 0; run_len = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(adoc_pkg::REG_PWR_MODE);
        `CHK(v, adoc_pkg::PWR_MODE_RST, "pwr mode reset")
        rd(adoc_pkg::REG_OUT_MODE);
        `CHK(v, adoc_pkg::OUT_MODE_RST, "out mode reset")
        rd(adoc_pkg::REG_FORMAT);
        `CHK(v, adoc_pkg::FORMAT_RST, "format reset")
        `CHK({ddr_mode, low_swing}, 2'b00, "mode pins at reset")
        wr(8'h33, 8'h5a);
        rd(8'h33);
        `CHK(v, 8'h00, "unmapped")
        for (int i = 0; i < 40 && locked !== 1'b1; i++) @(posedge clk);
        `CHK(locked, 1'b1, "lock after reset")
        `CHK(dout_oe_n, 1'b0, "drivers on")
        for (int f = 0; f < 2; f++) begin
            wr(adoc_pkg::REG_OUT_MODE, {7'h00, f[0]});
            twos = f[0];
            chk_en <= 1'b1;
            r0 = rise_cnt;
            repeat (200) begin
                @(posedge clk);
                next_raw();
            end
            #1;
            `CHK(rise_cnt - r0, 200, "dco rate")
            chk_en <= 1'b0;
        end
        wr(adoc_pkg::REG_OUT_MODE, 8'h08);
        `CHK(ddr_mode, 1'b1, "ddr select")
        r0 = fall_cnt;
        repeat (20) @(posedge clk);
        #1;
        `CHK(fall_cnt - r0, 20, "ddr edges")
        wr(adoc_pkg::REG_OUT_MODE, 8'h00);
        twos = 1'b0;
        wr(adoc_pkg::REG_FORMAT, 8'h03);
        #1;
        `CHK(low_swing, 1'b1, "low swing")
        wr(adoc_pkg::REG_FORMAT, 8'h00);
        repeat (3) @(posedge clk);
        #1;
        `CHK(locked, 1'b0, "stabilizer off")
        wr(adoc_pkg::REG_FORMAT, 8'h01);
        repeat (4) @(posedge clk);
        #1;
        `CHK(locked, 1'b0, "relock too early")
        for (int i = 0; i < 12 && locked !== 1'b1; i++) @(posedge clk);
        `CHK(locked, 1'b1, "relock")
        for (int m = 0; m < 2; m++) begin
            wr(adoc_pkg::REG_PWR_MODE, {7'h00, m[0]});
            power_down_pin <= 1'b1;
            repeat (5) @(posedge clk);
            #1;
            `CHK(dout_oe_n, m[0], "drivers off")
            rd(adoc_pkg::REG_STATUS);
            `CHK(v[3:0], m ? adoc_pkg::ADOC_OFF : adoc_pkg::ADOC_STANDBY, "pd state")
            power_down_pin <= 1'b0;
            for (int i = 0; i < 30 && v[3:0] !== adoc_pkg::ADOC_RUN; i++) rd(adoc_pkg::REG_STATUS);
            `CHK(v[3:0], adoc_pkg::ADOC_RUN, "wake")
            `CHK(dout_oe_n, 1'b0, "drivers back")
        end
        @(posedge clk);
        #25;
        clk_stop = 1;
        #1000;
        clk_stop = 0;
        r0 = 0;
        for (int i = 0; i < 6; i++) begin
            rd(adoc_pkg::REG_STATUS);
            if (v[3:0] !== adoc_pkg::ADOC_RUN) r0 = 1;
        end
        `CHK(r0, 1, "clock standby")
        for (int i = 0; i < 20 && v[3:0] !== adoc_pkg::ADOC_RUN; i++) rd(adoc_pkg::REG_STATUS);
        `CHK(v[3:0], adoc_pkg::ADOC_RUN, "resume")
        chk_en <= 1'b1;
        repeat (40) begin
            @(posedge clk);
            next_raw();
        end
        chk_en <= 1'b0;
        summarize();
    end
endmodule : testbench
